// file: logic/anp_pkg.sv
// Package for the auto-negotiation next page transmit register block
`default_nettype none
package anp_pkg;
	localparam logic [4:0] ANP_ADDR_NP_TX = 5'h07;
	localparam logic [4:0] ANP_ADDR_EXPANSION = 5'h06;
	localparam int ANP_BIT_MORE_PAGES = 15;
	localparam int ANP_BIT_RESERVED = 14;
	localparam int ANP_BIT_MSG_PAGE = 13;
	localparam int ANP_BIT_COMPLY = 12;
	localparam int ANP_BIT_TOGGLE = 11;
	localparam int ANP_CODE_W = 11;
	localparam int ANP_BIT_PAGE_RX = 1;
	localparam logic [10:0] ANP_CODE_RST = 11'h001;
	localparam logic ANP_MORE_PAGES_RST = 1'b0;
	localparam logic ANP_MSG_PAGE_RST = 1'b1;
	localparam logic ANP_COMPLY_RST = 1'b0;
	localparam logic ANP_TOGGLE_RST = 1'b0;

	typedef struct packed {
		logic more_pages_flag;
		logic message_page_select;
		logic comply_acknowledge;
		logic tx_toggle_bit;
		logic [10:0] code;
	} anp_page_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [4:0] addr;
		logic [15:0] wdata;
	} anp_mgmt_req_t;
endpackage
`default_nettype wire

// file: logic/anp_next_page_tx.sv
// Next page transmit register with toggle tracking and page-received flag
`timescale 1ns/10ps
`default_nettype none
module anp_next_page_tx
	import anp_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input var anp_mgmt_req_t i_mgmt_req,
	input wire logic i_page_sent,
	input wire logic i_page_received,
	output logic [15:0] o_rdata,
	output var anp_page_t o_tx_page
);
	anp_page_t page_q, page_d;
	logic page_rx_q, page_rx_d;
	logic [15:0] rdata_q, rdata_d;
	logic wr_np, rd_exp;

	function automatic logic [15:0] anp_pack(input anp_page_t p);
		logic [15:0] w;
		w = 16'h0000;
		w[ANP_BIT_MORE_PAGES] = p.more_pages_flag;
		w[ANP_BIT_MSG_PAGE] = p.message_page_select;
		w[ANP_BIT_COMPLY] = p.comply_acknowledge;
		w[ANP_BIT_TOGGLE] = p.tx_toggle_bit;
		w[ANP_CODE_W-1:0] = p.code;
		return w; // Bit 14 stays zero
	endfunction

	// Address match is shared by the write path and both read paths
	function automatic logic anp_hit(input logic [4:0] a, input logic [4:0] target);
		return a == target;
	endfunction

	assign wr_np = i_mgmt_req.wr && anp_hit(i_mgmt_req.addr, ANP_ADDR_NP_TX);
	assign rd_exp = i_mgmt_req.rd && anp_hit(i_mgmt_req.addr, ANP_ADDR_EXPANSION);

	// Page contents: software fields from writes, toggle from the transmit side
	always_comb begin
		page_d = page_q;
		if (wr_np) begin
			page_d.more_pages_flag = i_mgmt_req.wdata[ANP_BIT_MORE_PAGES];
			page_d.message_page_select = i_mgmt_req.wdata[ANP_BIT_MSG_PAGE];
			page_d.comply_acknowledge = i_mgmt_req.wdata[ANP_BIT_COMPLY];
			page_d.code = i_mgmt_req.wdata[ANP_CODE_W-1:0];
		end
		// Toggle is hardware owned; software writes never reach it
		if (i_page_sent) begin
			page_d.tx_toggle_bit = ~page_q.tx_toggle_bit;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			page_q <= '{ANP_MORE_PAGES_RST, ANP_MSG_PAGE_RST, ANP_COMPLY_RST,
				ANP_TOGGLE_RST, ANP_CODE_RST};
		end else begin
			page_q <= page_d;
		end
	end

	// Set wins over the read clear so a page arriving with the read is kept
	always_comb begin
		page_rx_d = page_rx_q;
		if (rd_exp) begin
			page_rx_d = 1'b0;
		end
		if (i_page_received) begin
			page_rx_d = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			page_rx_q <= 1'b0;
		end else begin
			page_rx_q <= page_rx_d;
		end
	end

	// Read data is held between reads so a slow master can still pick it up
	always_comb begin
		rdata_d = rdata_q;
		if (i_mgmt_req.rd) begin
			rdata_d = 16'h0000;
			if (anp_hit(i_mgmt_req.addr, ANP_ADDR_NP_TX)) begin
				rdata_d = anp_pack(page_q);
			end else if (rd_exp) begin
				rdata_d[ANP_BIT_PAGE_RX] = page_rx_q;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_tx_page = page_q;

	property p_toggle_flips;
		@(posedge i_core_clk) disable iff (i_srst)
		i_page_sent |=> o_tx_page.tx_toggle_bit != $past(o_tx_page.tx_toggle_bit);
	endproperty
	a_toggle_flips: assert property (p_toggle_flips) else $error("toggle did not flip");

	property p_toggle_holds;
		@(posedge i_core_clk) disable iff (i_srst)
		!i_page_sent |=> $stable(o_tx_page.tx_toggle_bit);
	endproperty
	a_toggle_holds: assert property (p_toggle_holds) else $error("toggle moved");

	property p_reserved_zero;
		@(posedge i_core_clk) disable iff (i_srst)
		i_mgmt_req.rd && i_mgmt_req.addr == ANP_ADDR_NP_TX |=> o_rdata[ANP_BIT_RESERVED] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_more_pages_wr;
		@(posedge i_core_clk) disable iff (i_srst)
		wr_np |=> o_tx_page.more_pages_flag == $past(i_mgmt_req.wdata[15]);
	endproperty
	a_more_pages_wr: assert property (p_more_pages_wr) else $error("more pages not written");

	property p_msg_sel_wr;
		@(posedge i_core_clk) disable iff (i_srst)
		wr_np |=> o_tx_page.message_page_select == $past(i_mgmt_req.wdata[13]);
	endproperty
	a_msg_sel_wr: assert property (p_msg_sel_wr) else $error("page select not written");

	property p_comply_wr;
		@(posedge i_core_clk) disable iff (i_srst)
		wr_np |=> o_tx_page.comply_acknowledge == $past(i_mgmt_req.wdata[12]);
	endproperty
	a_comply_wr: assert property (p_comply_wr) else $error("comply not written");

	property p_code_wr;
		@(posedge i_core_clk) disable iff (i_srst)
		wr_np |=> o_tx_page.code == $past(i_mgmt_req.wdata[10:0]);
	endproperty
	a_code_wr: assert property (p_code_wr) else $error("code not written");

	property p_reset_vals;
		@(posedge i_core_clk)
		i_srst |=> o_tx_page.code == ANP_CODE_RST && o_tx_page.message_page_select
			&& !o_tx_page.more_pages_flag && !o_tx_page.comply_acknowledge;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

	property p_page_rx_set;
		@(posedge i_core_clk) disable iff (i_srst)
		i_page_received |=> page_rx_q;
	endproperty
	a_page_rx_set: assert property (p_page_rx_set) else $error("page rx lost");

	property p_page_rx_clear;
		@(posedge i_core_clk) disable iff (i_srst)
		rd_exp && !i_page_received |=> !page_rx_q;
	endproperty
	a_page_rx_clear: assert property (p_page_rx_clear) else $error("page rx not cleared");

	property p_page_rx_read;
		@(posedge i_core_clk) disable iff (i_srst)
		rd_exp && page_rx_q |=> o_rdata[ANP_BIT_PAGE_RX];
	endproperty
	a_page_rx_read: assert property (p_page_rx_read) else $error("rx flag unread");

	property p_page_rx_holds;
		@(posedge i_core_clk) disable iff (i_srst)
		!rd_exp && !i_page_received |=> $stable(page_rx_q);
	endproperty
	a_page_rx_holds: assert property (p_page_rx_holds) else $error("rx flag moved");

	property p_exp_other_zero;
		@(posedge i_core_clk) disable iff (i_srst)
		rd_exp |=> o_rdata[15:2] == 14'h0000 && !o_rdata[0];
	endproperty
	a_exp_other_zero: assert property (p_exp_other_zero) else $error("exp bits set");

	property p_reset_rx;
		@(posedge i_core_clk)
		i_srst |=> !page_rx_q && o_rdata == 16'h0000;
	endproperty
	a_reset_rx: assert property (p_reset_rx) else $error("bad rx reset");

	// The read word is compared whole against the page one cycle earlier, with bit 14 zero
	property p_np_read;
		@(posedge i_core_clk) disable iff (i_srst)
		i_mgmt_req.rd && i_mgmt_req.addr == ANP_ADDR_NP_TX
			|=> o_rdata == {$past(o_tx_page.more_pages_flag), 1'b0, $past(o_tx_page[13:0])};
	endproperty
	a_np_read: assert property (p_np_read) else $error("bad page read");

	property p_unmapped_zero;
		@(posedge i_core_clk) disable iff (i_srst)
		i_mgmt_req.rd && i_mgmt_req.addr != ANP_ADDR_NP_TX
			&& i_mgmt_req.addr != ANP_ADDR_EXPANSION |=> o_rdata == 16'h0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");

	property p_rdata_holds;
		@(posedge i_core_clk) disable iff (i_srst)
		!i_mgmt_req.rd |=> $stable(o_rdata);
	endproperty
	a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");

	property p_page_holds;
		@(posedge i_core_clk) disable iff (i_srst)
		!wr_np && !i_page_sent |=> $stable(o_tx_page);
	endproperty
	a_page_holds: assert property (p_page_holds) else $error("page moved");
endmodule
`default_nettype wire

// file: dv/anp_partner_model.sv
// Link partner stub: answers each sent page with a received page
`timescale 1ns/10ps
`default_nettype none
module anp_partner_model (
	input wire logic i_core_clk,
	input wire logic i_go,
	input wire logic [3:0] i_lag,
	output logic o_page_sent = 1'h0,
	output logic o_page_received = 1'h0
);
	// Lag comes from the bench so the partner can be both prompt and slow
	always @(posedge i_core_clk) begin
		if (i_go) begin
			repeat (i_lag) @(posedge i_core_clk);
			o_page_sent <= 1'h1;
			@(posedge i_core_clk);
			o_page_sent <= 1'h0;
			o_page_received <= 1'h1;
			@(posedge i_core_clk);
			o_page_received <= 1'h0;
		end
	end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the next page transmit register
`timescale 1ns/10ps
`default_nettype none
module testbench import anp_pkg::*;;
	logic clk = 1'h0, srst = 1'h1, go = 1'h0, rd_d = 1'h0, sent, recv;
	logic [3:0] lag = 4'h0;
	logic [15:0] rdata, ew, q[$];
	logic [31:0] lfsr = 32'hFEA2;
	anp_mgmt_req_t req = '0;
	anp_page_t page;
	int n_errors = 0, num_checks = 0;
	always #5 clk = ~clk;
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	anp_next_page_tx i_dut(.i_core_clk(clk), .i_srst(srst), .i_mgmt_req(req),
		.i_page_sent(sent), .i_page_received(recv), .o_rdata(rdata), .o_tx_page(page));
	anp_partner_model i_partner(.i_core_clk(clk), .i_go(go), .i_lag(lag),
		.o_page_sent(sent), .o_page_received(recv));
	task automatic check(logic [15:0] s, logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Expected read words are queued at issue and retired on the falling edge after the read is registered
	task automatic acc(logic w, logic [4:0] a, logic [15:0] d, logic [15:0] e);
		req <= '{rd: !w, wr: w, addr: a, wdata: d};
		if (!w) q.push_back(e);
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask
	always @(posedge clk) rd_d <= req.rd;
	always @(negedge clk) if (rd_d) check(rdata, q.pop_front());
	task automatic results;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		results;
	end
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		acc(1'h0, 5'h07, 16'h0, 16'h2001);
		acc(1'h1, 5'h07, 16'hFFFF, 16'h0);
		ew = 16'hB7FF;
		acc(1'h0, 5'h07, 16'h0, ew);
		check({page[14], 1'h0, page[13:0]}, ew);
		$display("reset and write test done");
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			acc(1'h1, 5'h07, lfsr[15:0], 16'h0);
			ew = (lfsr[15:0] & 16'hB7FF) | (ew & 16'h0800);
			acc(1'h0, 5'h07, 16'h0, ew);
			go <= 1'h1;
			lag <= lfsr[19:16];
			@(posedge clk);
			go <= 1'h0;
			for (int k = 0; k < 24 && recv !== 1'h1; k++) @(posedge clk);
			ew = ew ^ 16'h0800;
			acc(1'h0, 5'h07, 16'h0, ew);
			check({page[14], 1'h0, page[13:0]}, ew);
			acc(1'h0, 5'h06, 16'h0, 16'h0002);
			acc(1'h0, 5'h06, 16'h0, 16'h0);
		end
		$display("page exchange test done");
		acc(1'h1, 5'h06, 16'hFFFF, 16'h0);
		acc(1'h0, 5'h1F, 16'h0, 16'h0);
		acc(1'h0, 5'h07, 16'h0, ew);
		srst <= 1'h1;
		@(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		acc(1'h0, 5'h07, 16'h0, 16'h2001);
		$display("unmapped and reset test done");
		results;
	end
endmodule
`default_nettype wire
